// file: rtl/crrc_pkg.sv
package crrc_pkg;
  // width of the runaway counter in bits, giving 2^20 oscillation clocks
  localparam int          CRRC_CNT_WIDTH       = 20;
  localparam int          CRRC_OSC_HZ          = 4000000;
  localparam int          CRRC_CORE_HZ         = 25000000;
  localparam int          CRRC_CORE_PERIOD_NS  = 40;
  // extra wake-up allowance, in ns
  localparam int          CRRC_WAKE_EXTRA_NS   = 20000;
  localparam int          CRRC_WAKE_EXTRA_CYC  = CRRC_WAKE_EXTRA_NS / CRRC_CORE_PERIOD_NS;
  localparam int          CRRC_RST_MCYC        = 5;
  localparam logic [19:0] CRRC_CNT_RESET       = 20'h00000;
  localparam logic [15:0] CRRC_EXTRA_RESET     = 16'h0000;
  localparam logic [2:0]  CRRC_PULSE_RESET     = 3'h0;
endpackage

// file: rtl/crrc_pulse_gen.sv
`timescale 1ns/10ps
// stretches a trigger into a pulse of a fixed number of machine cycles
module crrc_pulse_gen
  import crrc_pkg::*;
#(
  parameter int WIDTH = CRRC_RST_MCYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic machCycle,
  input  wire logic trigger,
  output logic      pulseOut
);
  typedef struct packed {
    logic [2:0] left;
    logic       act;
  } crrc_pg_type;

  crrc_pg_type st_r;
  crrc_pg_type st_nxt;

  initial begin
    if (WIDTH < 1 || WIDTH > 7) $error("pulse width out of range");
  end

  always_comb begin
    st_nxt = st_r;
    if (!st_r.act && trigger) begin
      st_nxt.act  = 1'b1;
      st_nxt.left = 3'(WIDTH);
    end else if (st_r.act && machCycle) begin
      if (st_r.left == 3'h1) begin
        st_nxt.act  = 1'b0;
        st_nxt.left = CRRC_PULSE_RESET;
      end else begin
        st_nxt.left = st_r.left - 3'h1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= '{left: CRRC_PULSE_RESET, act: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign pulseOut = st_r.act;
endmodule

// file: rtl/crrc_runaway_counter.sv
`timescale 1ns/10ps
// Functional notes
// [RULE1] counter runs by itself after power-on reset
// [RULE2] software clears counter regularly before timeout
// [RULE3] timeout without clear raises internal reset
// [RULE4] timeout is 2^20 oscillation clocks
// [RULE5] internal reset lasts five machine cycles
// [RULE6] wake from standby adds twenty microseconds
// [RULE7] counter halts while CPU is stopped
// [RULE8] writing zero to clear bit clears counter
// [RULE9] internal reset or oscillator stop clears counter
// [RULE10] entering sleep, timebase or watch clears
// [RULE11] twenty-bit counter stepped by oscillation clock
// [RULE12] every clear restarts counting from zero
module crrc_runaway_counter
  import crrc_pkg::*;
#(
  parameter int CNT_WIDTH = CRRC_CNT_WIDTH,
  parameter int EXTRA_CYC = CRRC_WAKE_EXTRA_CYC
) (
  input  wire logic core_clk,
  input  wire logic rst_n,
  input  wire logic oscTick,
  input  wire logic machCycle,
  input  wire logic clearBitWrite,
  input  wire logic clearBitValue,
  input  wire logic internalReset,
  input  wire logic mainOscStopped,
  input  wire logic enterSleep,
  input  wire logic enterTimebase,
  input  wire logic enterWatch,
  input  wire logic cpuStopped,
  input  wire logic standbyWake,
  output logic      runawayReset,
  output logic      timeoutPending,
  output logic [19:0] countValue
);
  typedef enum logic [1:0] {COUNTING, EXTRA_WAIT, FIRING} crrc_state_type;

  typedef struct packed {
    crrc_state_type state;
    logic [19:0]    cnt;
    logic [15:0]    extra;
    logic           waking;
    logic           fire;
    logic [2:0]     pulseMc;
  } crrc_st_type;

  crrc_st_type st_r;
  crrc_st_type st_nxt;
  logic        clearEvt;
  logic        wrap;
  logic        pulseOut;

  // narrower widths only shorten a simulated interval; the default is the full one
  localparam logic [19:0] CNT_LAST = 20'((1 << CNT_WIDTH) - 1);

  initial begin
    if (CNT_WIDTH < 4 || CNT_WIDTH > 20) $error("counter width out of range");
    if (EXTRA_CYC < 1 || EXTRA_CYC > 65535) $error("extra wait out of range");
  end

  // a clear is any software zero write or a hardware cause
  assign clearEvt = (clearBitWrite && !clearBitValue)             // RULE8
                  || internalReset || mainOscStopped              // RULE9
                  || enterSleep || enterTimebase || enterWatch;   // RULE10
  assign wrap = (st_r.cnt == CNT_LAST) && oscTick;                // RULE4

  always_comb begin
    st_nxt      = st_r;
    st_nxt.fire = 1'b0;
    // machine cycles seen while the pulse stands, for the width check
    if (!pulseOut) begin
      st_nxt.pulseMc = CRRC_PULSE_RESET;
    end else if (machCycle && st_r.pulseMc != 3'h7) begin
      st_nxt.pulseMc = st_r.pulseMc + 3'h1;
    end
    if (standbyWake) begin
      st_nxt.waking = 1'b1;
    end
    if (clearEvt) begin
      // clear wins over the timeout in the same cycle
      st_nxt.cnt    = CRRC_CNT_RESET;                             // RULE12
      st_nxt.extra  = CRRC_EXTRA_RESET;
      st_nxt.waking = standbyWake;
      st_nxt.state  = (st_r.state == FIRING) ? FIRING : COUNTING;
    end else if (!cpuStopped) begin                               // RULE7
      case (st_r.state)
        COUNTING: begin
          if (oscTick) begin
            st_nxt.cnt = st_r.cnt + 20'h00001;                    // RULE11
          end
          if (wrap) begin
            // a narrow counter must not spill past its top bit
            st_nxt.cnt = CRRC_CNT_RESET;
            if (st_r.waking) begin
              st_nxt.state = EXTRA_WAIT;                          // RULE6
              st_nxt.extra = 16'(EXTRA_CYC);
            end else begin
              st_nxt.state = FIRING;                              // RULE3
              st_nxt.fire  = 1'b1;
            end
          end
        end
        EXTRA_WAIT: begin
          if (st_r.extra == 16'h0001) begin
            st_nxt.state  = FIRING;
            st_nxt.fire   = 1'b1;
            // a wake starting now still arms the next timeout
            st_nxt.waking = standbyWake;
          end else begin
            st_nxt.extra = st_r.extra - 16'h0001;
          end
        end
        FIRING: begin
          if (!pulseOut && !st_r.fire) begin
            st_nxt.state = COUNTING;
            st_nxt.cnt   = CRRC_CNT_RESET;
          end
        end
        default: st_nxt.state = COUNTING;
      endcase
    end
    if (st_r.state == FIRING && !pulseOut && !st_r.fire) begin
      st_nxt.state = COUNTING;
    end
  end

  // reset leaves the counter running with no enable needed
  always_ff @(posedge core_clk or negedge rst_n) begin            // RULE1
    if (!rst_n) begin
      st_r <= '{state: COUNTING, cnt: CRRC_CNT_RESET, extra: CRRC_EXTRA_RESET,
                waking: 1'b0, fire: 1'b0, pulseMc: CRRC_PULSE_RESET};
    end else begin
      st_r <= st_nxt;
    end
  end

  crrc_pulse_gen #(
    .WIDTH (CRRC_RST_MCYC)
  ) u_pulse (
    .core_clk  (core_clk),
    .rst_n     (rst_n),
    .machCycle (machCycle),
    .trigger   (st_r.fire),                                       // RULE5
    .pulseOut  (pulseOut)
  );

  assign runawayReset   = pulseOut;
  assign timeoutPending = (st_r.state == EXTRA_WAIT);
  assign countValue     = st_r.cnt;

  // counter checks
  AST_CLEAR_ZEROES: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE12
    clearEvt |=> (countValue == 20'h00000))
    else $error("counter not zero after clear");
  AST_SW_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE8
    (clearBitWrite && !clearBitValue) |=> countValue == 20'h00000)
    else $error("software clear ignored");
  AST_HW_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE9
    (internalReset || mainOscStopped) |=> countValue == 20'h00000)
    else $error("hardware clear ignored");
  AST_MODE_CLEAR: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE10
    (enterSleep || enterTimebase || enterWatch) |=> countValue == 20'h00000)
    else $error("mode entry clear ignored");
  AST_HALT: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE7
    (cpuStopped && !clearEvt) |=> $stable(countValue))
    else $error("counter moved while cpu stopped");
  AST_HALT_EXTRA: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE7
    (timeoutPending && cpuStopped && !clearEvt) |=> timeoutPending)
    else $error("wake wait left while cpu stopped");
  AST_STEP: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE11
    (oscTick && !cpuStopped && !clearEvt && st_r.state == COUNTING && !wrap)
      |=> countValue == $past(countValue) + 20'h00001)
    else $error("counter did not step");
  AST_CLEAR_BEATS: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE12
    (wrap && clearEvt) |=> !st_r.fire)
    else $error("timeout fired despite clear");
  AST_RESUME: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE12
    $fell(runawayReset) |=> (countValue == 20'h00000 && !timeoutPending))
    else $error("counter did not restart after reset pulse");

  // reset pulse and wake allowance
  AST_FIRE: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE3
    (wrap && !clearEvt && !cpuStopped && st_r.state == COUNTING && !st_r.waking)
      |=> ##1 runawayReset)
    else $error("timeout did not reset");
  AST_NO_EARLY: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE4
    $rose(runawayReset) |-> $past(st_r.fire))
    else $error("reset without timeout");
  AST_WIDTH: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE5
    (runawayReset && machCycle && st_r.pulseMc == 3'(CRRC_RST_MCYC - 1))
      |=> !runawayReset)
    else $error("reset pulse too long");
  AST_PULSE_HOLD: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE5
    (runawayReset && !(machCycle && st_r.pulseMc == 3'(CRRC_RST_MCYC - 1)))
      |=> runawayReset)
    else $error("reset pulse cut short");
  AST_WAKE: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE6
    (wrap && !clearEvt && !cpuStopped && st_r.state == COUNTING && st_r.waking)
      |=> !runawayReset [*2])
    else $error("wake allowance skipped");
  AST_WAKE_ARMS: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE6
    standbyWake |=> st_r.waking)
    else $error("wake request lost");
  AST_PENDING_WAKE: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE6
    $rose(timeoutPending) |-> $past(st_r.waking))
    else $error("wake wait without wake");
  AST_EXTRA_END: assert property (@(posedge core_clk) disable iff (!rst_n) // RULE6
    (timeoutPending && st_r.extra == 16'h0001 && !clearEvt && !cpuStopped)
      |=> ##1 runawayReset)
    else $error("wake wait did not end in reset");

  COV_FIRE: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(runawayReset));
  COV_WAKE: cover property (@(posedge core_clk) disable iff (!rst_n) timeoutPending);
  COV_CLEAR: cover property (@(posedge core_clk) disable iff (!rst_n)
    clearBitWrite && !clearBitValue);
  COV_PULSE_END: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(runawayReset));
  COV_HALT: cover property (@(posedge core_clk) disable iff (!rst_n) cpuStopped && oscTick);
endmodule

// file: tb/crrc_sw_model.sv
`timescale 1ns/10ps
// software servicing the counter at a fixed spacing
module crrc_sw_model #(
  parameter int PERIOD = 8
) (
  input  wire logic core_clk,
  input  wire logic en,
  output logic      clrWrite,
  output logic      clrValue
);
  int cnt = 0;

  initial clrWrite = 1'b0;
  // released value line shows the non-clearing level
  assign clrValue = clrWrite ? 1'b0 : 1'b1;

  always @(negedge core_clk) begin
    cnt = en ? (cnt + 1) % PERIOD : 0;
    clrWrite <= en && cnt == 0;
  end
endmodule

// file: tb/tb.sv
`timescale 1ns/10ps
module tb;
  typedef struct {int ticks; logic [7:0] ctl; logic [19:0] exp;} crrc_row_type;
  localparam int EXTRA = 4;
  localparam int CW = 12;
  localparam int TICKS = (1 << CW) - 1;
  logic         core_clk = 1'b0;
  logic         rst_n = 1'b0;
  logic         oscTick = 1'b0;
  logic         machCycle = 1'b0;
  logic         standbyWake = 1'b0;
  logic         swEn = 1'b0;
  logic [7:0]   ctl = 8'h00;
  logic [1:0]   mc = 2'h0;
  logic         tbWrite, tbValue, internalReset, mainOscStopped, enterSleep;
  logic         enterTimebase, enterWatch, cpuStopped, swWrite, swValue;
  logic         runawayReset, timeoutPending, seen;
  logic [19:0]  countValue;
  int           n_mismatch = 0;
  int           n_checks = 0;
  int           k, m, p;
  crrc_row_type rows [9] = '{'{5, 8'h00, 20'h00006}, '{5, 8'h40, 20'h00000},
    '{5, 8'h60, 20'h00006}, '{5, 8'h10, 20'h00000}, '{5, 8'h08, 20'h00000},
    '{5, 8'h04, 20'h00000}, '{5, 8'h02, 20'h00000}, '{5, 8'h01, 20'h00000},
    '{5, 8'h80, 20'h00005}};

  assign {cpuStopped, tbWrite, tbValue, internalReset, mainOscStopped, enterSleep,
          enterTimebase, enterWatch} = ctl;

  crrc_sw_model #(.PERIOD(8)) i_crrc_sw_model (.core_clk, .en(swEn), .clrWrite(swWrite),
    .clrValue(swValue));
  crrc_runaway_counter #(.CNT_WIDTH(CW), .EXTRA_CYC(EXTRA)) i_crrc_runaway_counter (
    .core_clk, .rst_n,
    .oscTick, .machCycle, .clearBitWrite(swWrite | tbWrite),
    .clearBitValue(swWrite ? swValue : tbValue), .internalReset, .mainOscStopped,
    .enterSleep, .enterTimebase, .enterWatch, .cpuStopped, .standbyWake, .runawayReset,
    .timeoutPending, .countValue);

  initial forever #20 core_clk = ~core_clk;

  // machine cycle every third clock, so the pulse spans many clocks
  always @(negedge core_clk) begin
    mc <= (mc == 2'h2) ? 2'h0 : mc + 2'h1;
    machCycle <= (mc == 2'h2);
  end

  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("MISMATCH %0t %s", $time, msg);
    end
  endtask

  task automatic drive(input logic [7:0] c, input logic t);
    @(negedge core_clk);
    ctl = c;
    oscTick = t;
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    chk(countValue === 20'h00000 && runawayReset === 1'b0, "reset values");
    @(negedge core_clk);
    rst_n = 1'b1;
    foreach (rows[i]) begin
      drive(8'h10, 1'b0);
      repeat (rows[i].ticks) drive(8'h00, 1'b1);
      drive(rows[i].ctl, 1'b1);
      drive(8'h00, 1'b0);
      chk(countValue === rows[i].exp, "table row");
    end
    // hardware clear first so the servicing phase starts from zero
    drive(8'h10, 1'b1);
    swEn = 1'b1;
    drive(8'h00, 1'b1);
    seen = 1'b0;
    repeat (200) begin
      @(negedge core_clk);
      seen |= (countValue > 20'h00007) | runawayReset;
    end
    chk(seen === 1'b0, "serviced counter ran over");
    swEn = 1'b0;
    // wake armed in the clearing cycle so the clear keeps it
    drive(8'h10, 1'b0);
    standbyWake = 1'b1;
    drive(8'h00, 1'b1);
    standbyWake = 1'b0;
    k = 0;
    while (countValue !== 20'(TICKS) && k < 5000) begin
      @(negedge core_clk);
      k++;
    end
    chk(k == TICKS && runawayReset === 1'b0, "interval length");
    m = 0;
    seen = 1'b0;
    while (runawayReset !== 1'b1 && m < 100) begin
      @(negedge core_clk);
      m++;
      seen |= timeoutPending;
    end
    chk(seen === 1'b1 && m == EXTRA + 2, "wake allowance");
    p = 0;
    m = 0;
    while (runawayReset === 1'b1 && m < 100) begin
      @(posedge core_clk);
      #1;
      p += int'(machCycle);
      m++;
    end
    chk(p == 5 && runawayReset === 1'b0, "pulse width");
    chk(countValue < 20'h00010, "restart after timeout");
    // a second timeout with no wake armed takes no extra wait
    drive(8'h10, 1'b0);
    drive(8'h00, 1'b1);
    m = 0;
    seen = 1'b0;
    while (runawayReset !== 1'b1 && m < 5000) begin
      @(negedge core_clk);
      m++;
      seen |= timeoutPending;
    end
    chk(seen === 1'b0 && m == TICKS + 2, "plain timeout");
    @(negedge core_clk);
    rst_n = 1'b0;
    @(posedge core_clk);
    #1;
    chk(countValue === 20'h00000 && timeoutPending === 1'b0 && runawayReset === 1'b0,
        "reset mid-run");
    @(negedge core_clk);
    rst_n = 1'b1;
    repeat (3) @(negedge core_clk);
    chk(countValue === 20'h00003 && runawayReset === 1'b0, "count after release");
    wrap_up;
  end
endmodule
